// ==== srm_pkg.sv ====
// package for the soft-reset mask slice: register offsets, fields, resets
// assumes 32-bit apb with word-aligned registers
package srm_pkg;
	localparam logic [7:0]  SRM_REG_CONFIG   = 8'h00;
	localparam logic [7:0]  SRM_REG_STATION  = 8'h04;
	localparam logic [7:0]  SRM_REG_STATUS   = 8'h08;
	localparam logic [7:0]  SRM_REG_MASK     = 8'h0C;
	localparam logic [7:0]  SRM_REG_CONTROL  = 8'h10;
	localparam logic [7:0]  SRM_REG_PROBE    = 8'h14;
	localparam logic [7:0]  SRM_REG_EVENT    = 8'h18;
	localparam logic [7:0]  SRM_REG_EVMASK   = 8'h1C;
	localparam int          SRM_CFG_RESET_BIT = 7;
	localparam int          SRM_CTL_REFINE_BIT = 0;
	localparam int          SRM_ST_RXINH_BIT = 7;
	localparam int          SRM_ST_TXAV_BIT  = 0;
	localparam int          SRM_EV_SOFT_BIT  = 0;
	localparam logic [7:0]  SRM_CONFIG_RST   = 8'h00;
	localparam logic [7:0]  SRM_STATION_RST  = 8'h00;
	localparam logic [7:0]  SRM_STATUS_RST   = 8'h81;
	localparam logic [7:0]  SRM_MASK_RST     = 8'h00;
	localparam logic [7:0]  SRM_PROBE_RST    = 8'h00;
	// revision signature masks and probe pattern: values arbitrary, only bits 7:6 carry meaning
	localparam logic [7:0]  SRM_PROBE_KEEP_NEW = 8'hD3;
	localparam logic [7:0]  SRM_PROBE_KEEP_OLD = 8'hA5;
	localparam logic [7:0]  SRM_PROBE_PATTERN  = 8'hE5;
endpackage : srm_pkg

// ==== srm_top.sv ====
// soft-reset mask slice: config/station/status/mask registers and rev probe
// assumes an apb master on pclk; status flags otherwise set by the engine
//
// Notes on behaviour
// - with refinement enabled, mask clears on hard reset and every soft reset.
// - soft reset starts on station identifier written zero or config reset bit high.
// - soft reset sets receive-inhibit and transmitter-available flags to one.
// - with refinement disabled, mask survives soft reset; only hard reset clears it.
// - writing zero to probe index 5 reads back zero.
// - writing top two bits reads back revision dependent top-bit subset.
// - refinement enable resets to zero, keeping legacy behaviour.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module srm_top
	import srm_pkg::*;
#(
	parameter bit NEW_REVISION = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        set_rx_inhibit,
	input  wire logic        set_tx_avail,
	input  wire logic        clr_rx_inhibit,
	input  wire logic        clr_tx_avail,
	output logic             status_irq,
	output logic             soft_reset,
	output logic             irq
);
	logic [7:0] config_reg;
	logic [7:0] station_reg;
	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	logic       refine_reg;
	logic [7:0] probe_reg;
	logic       event_reg;
	logic       evmask_reg;
	logic       wr;
	logic       rd;
	logic       soft_pulse;
	logic       mapped;
	logic [7:0] keep;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign mapped  = hit(paddr, SRM_REG_CONFIG) || hit(paddr, SRM_REG_STATION) ||
		hit(paddr, SRM_REG_STATUS) || hit(paddr, SRM_REG_MASK) ||
		hit(paddr, SRM_REG_CONTROL) || hit(paddr, SRM_REG_PROBE) ||
		hit(paddr, SRM_REG_EVENT) || hit(paddr, SRM_REG_EVMASK);
	assign pslverr = psel && penable && !mapped;
	assign keep    = NEW_REVISION ? SRM_PROBE_KEEP_NEW : SRM_PROBE_KEEP_OLD;

	// soft reset pulse: station id written zero or reset bit written high
	assign soft_pulse = wr && ((hit(paddr, SRM_REG_STATION) && pwdata[7:0] == 8'h00) ||
		(hit(paddr, SRM_REG_CONFIG) && pwdata[SRM_CFG_RESET_BIT]));
	assign soft_reset = soft_pulse || config_reg[SRM_CFG_RESET_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg  <= SRM_CONFIG_RST;
			station_reg <= SRM_STATION_RST;
		end else if (wr && hit(paddr, SRM_REG_CONFIG)) begin
			config_reg <= pwdata[7:0];
		end else if (wr && hit(paddr, SRM_REG_STATION)) begin
			station_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refine_reg <= 1'b0;
		end else if (wr && hit(paddr, SRM_REG_CONTROL)) begin
			refine_reg <= pwdata[SRM_CTL_REFINE_BIT];
		end
	end

	// flags are set by soft reset; a set always wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= SRM_STATUS_RST;
		end else begin
			if (soft_reset) begin
				status_reg[SRM_ST_RXINH_BIT] <= 1'b1;
				status_reg[SRM_ST_TXAV_BIT]  <= 1'b1;
			end else begin
				if (set_rx_inhibit)
					status_reg[SRM_ST_RXINH_BIT] <= 1'b1;
				else if (clr_rx_inhibit)
					status_reg[SRM_ST_RXINH_BIT] <= 1'b0;
				if (set_tx_avail)
					status_reg[SRM_ST_TXAV_BIT] <= 1'b1;
				else if (clr_tx_avail)
					status_reg[SRM_ST_TXAV_BIT] <= 1'b0;
			end
		end
	end

	// legacy parts kept the mask over a soft reset, which raised a stray interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= SRM_MASK_RST;
		end else if (soft_reset && refine_reg) begin
			mask_reg <= SRM_MASK_RST;
		end else if (wr && hit(paddr, SRM_REG_MASK)) begin
			mask_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			probe_reg <= SRM_PROBE_RST;
		end else if (wr && hit(paddr, SRM_REG_PROBE)) begin
			probe_reg <= pwdata[7:0] & keep;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_reg  <= 1'b0;
			evmask_reg <= 1'b0;
		end else begin
			if (soft_reset)
				event_reg <= 1'b1;
			else if (wr && hit(paddr, SRM_REG_EVENT) && pwdata[SRM_EV_SOFT_BIT])
				event_reg <= 1'b0;
			if (wr && hit(paddr, SRM_REG_EVMASK))
				evmask_reg <= pwdata[SRM_EV_SOFT_BIT];
		end
	end

	assign status_irq = |(status_reg & mask_reg);
	assign irq        = event_reg && evmask_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				SRM_REG_CONFIG:  prdata <= {24'h00_0000, config_reg};
				SRM_REG_STATION: prdata <= {24'h00_0000, station_reg};
				SRM_REG_STATUS:  prdata <= {24'h00_0000, status_reg};
				SRM_REG_MASK:    prdata <= {24'h00_0000, mask_reg};
				SRM_REG_CONTROL: prdata <= {31'h0000_0000, refine_reg};
				SRM_REG_PROBE:   prdata <= {24'h00_0000, probe_reg};
				SRM_REG_EVENT:   prdata <= {31'h0000_0000, event_reg};
				SRM_REG_EVMASK:  prdata <= {31'h0000_0000, evmask_reg};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end

	property p_mask_clear;
		@(posedge pclk) disable iff (!presetn)
		(soft_reset && refine_reg) |=> mask_reg == SRM_MASK_RST;
	endproperty
	a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared");

	property p_soft_src;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, SRM_REG_STATION) && pwdata[7:0] == 8'h00) |-> soft_reset;
	endproperty
	a_soft_src: assert property (p_soft_src) else $error("no soft reset");

	property p_flags;
		@(posedge pclk) disable iff (!presetn)
		soft_reset |=> status_reg[SRM_ST_RXINH_BIT] && status_reg[SRM_ST_TXAV_BIT];
	endproperty
	a_flags: assert property (p_flags) else $error("flags not set");

	property p_mask_keep;
		@(posedge pclk) disable iff (!presetn)
		(soft_reset && !refine_reg && !wr) |=> $stable(mask_reg);
	endproperty
	a_mask_keep: assert property (p_mask_keep) else $error("mask lost");

	property p_probe_zero;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, SRM_REG_PROBE) && pwdata[7:0] == 8'h00) |=> probe_reg == 8'h00;
	endproperty
	a_probe_zero: assert property (p_probe_zero) else $error("probe not zero");

	property p_probe_rev;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, SRM_REG_PROBE)) |=> probe_reg == ($past(pwdata[7:0]) & keep);
	endproperty
	a_probe_rev: assert property (p_probe_rev) else $error("probe readback");

	property p_refine_legacy;
		@(posedge pclk) disable iff (!presetn)
		(!refine_reg && !(wr && hit(paddr, SRM_REG_CONTROL))) |=> !refine_reg;
	endproperty
	a_refine_legacy: assert property (p_refine_legacy) else $error("refine set");

	property p_no_glitch;
		@(posedge pclk) disable iff (!presetn)
		(soft_reset && refine_reg) |=> !status_irq;
	endproperty
	a_no_glitch: assert property (p_no_glitch) else $error("stray irq");

	property p_soft_cfg;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, SRM_REG_CONFIG) && pwdata[SRM_CFG_RESET_BIT]) |-> soft_reset;
	endproperty
	a_soft_cfg: assert property (p_soft_cfg) else $error("no config soft reset");

	// mask moves only by its own write or by a soft reset
	property p_mask_hold;
		@(posedge pclk) disable iff (!presetn)
		(!soft_reset && !(wr && hit(paddr, SRM_REG_MASK))) |=> $stable(mask_reg);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask moved");

	property p_event_set;
		@(posedge pclk) disable iff (!presetn)
		soft_reset |=> event_reg;
	endproperty
	a_event_set: assert property (p_event_set) else $error("event not set");
endmodule : srm_top

// ==== srm_host.sv ====
// host model: apb master that reaches the slice registers
// assumes pready answers on a rising pclk edge
`timescale 1ns/1ps
module srm_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// waits for pready with no cycle count assumed
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : srm_host

// ==== soft_reset_mask_and_rev_probe_test.sv ====
// self-checking bench for the soft-reset mask slice and revision probe
// assumes new and old revision slices on one bus; engine set inputs held idle
`timescale 1ns/1ps
module soft_reset_mask_and_rev_probe_test;
	import srm_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clr_rx = 1'b0;
	logic        clr_tx = 1'b0;
	logic        quiet = 1'b0;
	logic        sel_old = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, status_irq, soft_reset, irq;
	logic        pready_new, pready_old, pslverr_new, pslverr_old;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, prdata_new, prdata_old;
	int          fail_count = 0;
	int          n_checks = 0;
	always #20 pclk = ~pclk;
	// sel_old steers the single host to the old-revision slice
	assign prdata  = sel_old ? prdata_old : prdata_new;
	assign pready  = sel_old ? pready_old : pready_new;
	assign pslverr = sel_old ? pslverr_old : pslverr_new;
	srm_host h (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
	srm_top uut (.pclk, .presetn, .psel(psel && !sel_old), .penable, .pwrite, .paddr, .pwdata,
		.prdata(prdata_new), .pready(pready_new), .pslverr(pslverr_new), .set_rx_inhibit(1'b0),
		.set_tx_avail(1'b0), .clr_rx_inhibit(clr_rx), .clr_tx_avail(clr_tx), .status_irq,
		.soft_reset, .irq);
	srm_top #(.NEW_REVISION(1'b0)) uut_old (.pclk, .presetn, .psel(psel && sel_old), .penable,
		.pwrite, .paddr, .pwdata, .prdata(prdata_old), .pready(pready_old), .pslverr(pslverr_old),
		.set_rx_inhibit(1'b0), .set_tx_avail(1'b0), .clr_rx_inhibit(1'b0), .clr_tx_avail(1'b0),
		.status_irq(), .soft_reset(), .irq());
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		h.xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		h.xfer(1'b0, a, 32'h0000_0000, r, e);
		chk(r, exp);
	endtask : rdc
	task automatic clr_flags;
		@(posedge pclk);
		clr_rx <= 1'b1;
		clr_tx <= 1'b1;
		@(posedge pclk);
		clr_rx <= 1'b0;
		clr_tx <= 1'b0;
	endtask : clr_flags
	// interrupt must not even pulse while mask and flags swap
	always @(negedge pclk) if (quiet && status_irq !== 1'b0) chk(32'(status_irq), 0);
	task automatic t_reset;
		rdc(SRM_REG_STATUS, 32'(SRM_STATUS_RST));
		rdc(SRM_REG_CONTROL, 32'h0000_0000);
		rdc(SRM_REG_MASK, 32'(SRM_MASK_RST));
		$display("t_reset done");
	endtask : t_reset
	task automatic t_refine_on;
		wr(SRM_REG_CONTROL, 32'h0000_0001);
		wr(SRM_REG_MASK, 32'h0000_0081);
		clr_flags();
		quiet = 1'b1;
		wr(SRM_REG_STATION, 32'h0000_0000);
		rdc(SRM_REG_MASK, 32'h0000_0000);
		rdc(SRM_REG_STATUS, 32'h0000_0081);
		quiet = 1'b0;
		$display("t_refine_on done");
	endtask : t_refine_on
	task automatic t_refine_off;
		wr(SRM_REG_CONTROL, 32'h0000_0000);
		wr(SRM_REG_MASK, 32'h0000_0081);
		clr_flags();
		rdc(SRM_REG_STATUS, 32'h0000_0000);
		wr(SRM_REG_CONFIG, 32'h0000_0080);
		@(negedge pclk) chk(32'(soft_reset), 32'h0000_0001);
		wr(SRM_REG_CONFIG, 32'h0000_0000);
		@(negedge pclk) chk(32'(soft_reset), 32'h0000_0000);
		rdc(SRM_REG_MASK, 32'h0000_0081);
		rdc(SRM_REG_STATUS, 32'h0000_0081);
		@(negedge pclk) chk(32'(status_irq), 1);
		$display("t_refine_off done");
	endtask : t_refine_off
	task automatic t_irq;
		rdc(SRM_REG_EVENT, 32'h0000_0001);
		@(negedge pclk) chk(32'(irq), 0);
		wr(SRM_REG_EVMASK, 32'h0000_0001);
		@(negedge pclk) chk(32'(irq), 1);
		wr(SRM_REG_EVENT, 32'h0000_0001);
		@(negedge pclk) chk(32'(irq), 0);
		$display("t_irq done");
	endtask : t_irq
	task automatic t_probe;
		logic [31:0] r;
		logic        e;
		wr(SRM_REG_PROBE, 32'h0000_0000);
		rdc(SRM_REG_PROBE, 32'h0000_0000);
		wr(SRM_REG_PROBE, 32'(SRM_PROBE_PATTERN));
		h.xfer(1'b0, SRM_REG_PROBE, 32'h0000_0000, r, e);
		chk(r, 32'(SRM_PROBE_PATTERN & SRM_PROBE_KEEP_NEW));
		chk(32'(r[7:6]), 32'h0000_0003);
		h.xfer(1'b0, 8'h20, 32'h0000_0000, r, e);
		chk(32'(e), 1);
		$display("t_probe done");
	endtask : t_probe
	task automatic t_probe_old;
		logic [31:0] r;
		logic        e;
		sel_old <= 1'b1;
		wr(SRM_REG_PROBE, 32'h0000_0000);
		rdc(SRM_REG_PROBE, 32'h0000_0000);
		wr(SRM_REG_PROBE, 32'(SRM_PROBE_PATTERN));
		h.xfer(1'b0, SRM_REG_PROBE, 32'h0000_0000, r, e);
		chk(r, 32'(SRM_PROBE_PATTERN & SRM_PROBE_KEEP_OLD));
		chk(32'(r[7:6]), 32'h0000_0002);
		sel_old <= 1'b0;
		$display("t_probe_old done");
	endtask : t_probe_old
	// mid-run hard reset must clear a loaded mask and the refinement bit
	task automatic t_hard_reset;
		wr(SRM_REG_CONTROL, 32'h0000_0001);
		wr(SRM_REG_MASK, 32'h0000_0081);
		rdc(SRM_REG_MASK, 32'h0000_0081);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk) chk(32'(status_irq), 32'h0000_0000);
		rdc(SRM_REG_MASK, 32'(SRM_MASK_RST));
		rdc(SRM_REG_CONTROL, 32'h0000_0000);
		$display("t_hard_reset done");
	endtask : t_hard_reset
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_refine_on();
		t_refine_off();
		t_irq();
		t_hard_reset();
		t_probe();
		t_probe_old();
		print_verdict();
	end
endmodule : soft_reset_mask_and_rev_probe_test
